// *** src/pfd_pkg.sv ***
package pfd_pkg;

    // Stack fault selection bit positions
    localparam int unsigned SEL_ADDR_BIT  = 0;
    localparam int unsigned SEL_INTR_BIT  = 1;
    localparam int unsigned SEL_W         = 2;

    // Both stack fault resets are disabled after power-on or pin reset
    localparam logic [1:0] SEL_RST_VAL    = 2'h0;

    // Reset type codes, as seen by the block
    typedef enum logic [1:0] {
        PFD_RST_NONE  = 2'b00,
        PFD_RST_COLD  = 2'b01,
        PFD_RST_HANG  = 2'b11,
        PFD_RST_CE    = 2'b10
    } pfd_rst_kind_t;

    // Stack fault event group
    typedef struct packed {
        logic addr_ovf;
        logic addr_unf;
        logic intr_ovf;
        logic intr_unf;
    } pfd_stack_evt_t;

    // Write-once selection command
    typedef struct packed {
        logic       wr;
        logic [1:0] data;
    } pfd_sel_wr_t;

endpackage

// *** src/pfd_core.sv ***
`timescale 1ns/1ps
// What this block does
// - Selection register takes one write per cold reset
// - Separate address and interrupt stack fault enables
// - Power-on clear sets carry-disable; flag read clears
// - Carry-disable blocks timer carry flag setting
// - Flag starts cleared and blocked after power-on
// - After read, flag sets on each pulse rise
// - Fault flag holds through reads; 0 means cold reset
// - Reset pin acts like power-on clear here
// - CE high resets at next carry pulse rise
// - Firmware reads flag before next pulse rise
// - Firmware changes carry period only after init
// - Hang reset keeps selection, flag and disable
// - Enabled stack over/underflow raises hang reset
module pfd_core
    import pfd_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 por_clear,
    input  wire logic                 reset_pin_n,
    input  wire logic                 chip_enable,
    input  wire logic                 carry_pulse,
    input  wire logic                 flag_read,
    input  wire pfd_pkg::pfd_sel_wr_t sel_wr,
    input  wire pfd_pkg::pfd_stack_evt_t stack_evt,
    output logic                      timer_carry_flag,
    output logic                      carry_disable,
    output logic [1:0]                stack_sel,
    output logic                      sel_locked,
    output logic                      hang_fault_reset,
    output logic                      ce_reset,
    output logic                      fault_reset_flag
);
    import pfd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    logic       cold_rst;
    logic       pulse_q;
    logic       pulse_rise;
    logic       addr_fault;
    logic       intr_fault;
    logic       stack_fault;
    logic       sel_take;

    // Pin reset and power-on clear are both cold resets
    assign cold_rst    = sys_rst | por_clear | ~reset_pin_n;
    assign pulse_rise  = carry_pulse & ~pulse_q;
    assign addr_fault  = stack_evt.addr_ovf | stack_evt.addr_unf;
    assign intr_fault  = stack_evt.intr_ovf | stack_evt.intr_unf;
    // Each fault class gated by its own enable
    assign stack_fault = (addr_fault & stack_sel[SEL_ADDR_BIT]) | (intr_fault & stack_sel[SEL_INTR_BIT]);
    assign sel_take    = sel_wr.wr & ~sel_locked;

    ////////////////////////////////////////////////////////////////////////
    // Pulse edge history; survives hang resets
    always_ff @(posedge ref_clk) begin
        if (cold_rst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= carry_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carry-disable and flag; hang resets never touch them
    always_ff @(posedge ref_clk) begin
        if (cold_rst) begin
            carry_disable    <= 1'b1;
            timer_carry_flag <= 1'b0;
        end else begin
            if (flag_read) begin
                carry_disable <= 1'b0;
            end
            // A rise in the read cycle still sets when carry-disable is clear: set wins over clear
            // Letting the read win would lose one carry event for the firmware
            if (pulse_rise && !carry_disable) begin
                timer_carry_flag <= 1'b1;
            end else if (flag_read) begin
                timer_carry_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-once selection register
    always_ff @(posedge ref_clk) begin
        if (cold_rst) begin
            stack_sel  <= SEL_RST_VAL;
            sel_locked <= 1'b0;
        end else if (sel_take) begin
            stack_sel  <= sel_wr.data;
            sel_locked <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset outputs, registered
    always_ff @(posedge ref_clk) begin
        if (cold_rst) begin
            hang_fault_reset <= 1'b0;
            ce_reset         <= 1'b0;
            fault_reset_flag <= 1'b0;
        end else begin
            hang_fault_reset <= stack_fault;
            // A period change makes an early rise, so CE reset may come at once
            ce_reset         <= chip_enable & pulse_rise;
            if (stack_fault) begin
                fault_reset_flag <= 1'b1;
            end else if (flag_read) begin
                fault_reset_flag <= fault_reset_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Carry-disable and flag after a cold reset
    chk_cold_disable: assert property (@(posedge ref_clk) cold_rst |=> carry_disable && !timer_carry_flag)
        else $error("carry disable not set by cold reset");

    // Pin reset is a cold reset: selection back to default and unlocked
    chk_cold_sel: assert property (@(posedge ref_clk)
        cold_rst |=> stack_sel == SEL_RST_VAL && !sel_locked)
        else $error("selection not reset by cold reset");

    chk_blocked_flag: assert property (@(posedge ref_clk) disable iff (cold_rst)
        carry_disable && !flag_read |=> !timer_carry_flag || $past(timer_carry_flag))
        else $error("flag set while disabled");

    // Once cleared, only a cold reset can set carry-disable again
    chk_disable_holds: assert property (@(posedge ref_clk) disable iff (cold_rst)
        !carry_disable |=> !carry_disable)
        else $error("carry disable set without cold reset");

    chk_read_unblocks: assert property (@(posedge ref_clk) disable iff (cold_rst)
        flag_read |=> !carry_disable)
        else $error("read did not clear carry disable");

    chk_flag_sets: assert property (@(posedge ref_clk) disable iff (cold_rst)
        pulse_rise && !carry_disable |=> timer_carry_flag)
        else $error("flag missed a pulse rise");

    chk_read_clears: assert property (@(posedge ref_clk) disable iff (cold_rst)
        flag_read && !pulse_rise |=> !timer_carry_flag)
        else $error("read did not clear flag");

    // A read meeting a rise must not swallow the carry event
    chk_late_read: assert property (@(posedge ref_clk) disable iff (cold_rst)
        flag_read && pulse_rise && !carry_disable |=> timer_carry_flag)
        else $error("carry event lost to read");

    // Selection register
    chk_sel_once: assert property (@(posedge ref_clk) disable iff (cold_rst)
        sel_locked |=> $stable(stack_sel) && sel_locked)
        else $error("selection changed after lock");

    chk_sel_lands: assert property (@(posedge ref_clk) disable iff (cold_rst)
        sel_take |=> stack_sel == $past(sel_wr.data) && sel_locked)
        else $error("first selection write not taken");

    chk_sel_refused: assert property (@(posedge ref_clk) disable iff (cold_rst)
        sel_locked && sel_wr.wr |=> $stable(stack_sel))
        else $error("late selection write taken");

    // Stack fault reset gating
    chk_fault_gate: assert property (@(posedge ref_clk) disable iff (cold_rst)
        hang_fault_reset |-> $past(stack_sel) != 2'h0)
        else $error("fault reset with both enables off");

    chk_addr_enable: assert property (@(posedge ref_clk) disable iff (cold_rst)
        addr_fault && stack_sel[SEL_ADDR_BIT] |=> hang_fault_reset)
        else $error("address stack fault missed");

    chk_intr_enable: assert property (@(posedge ref_clk) disable iff (cold_rst)
        intr_fault && stack_sel[SEL_INTR_BIT] |=> hang_fault_reset)
        else $error("interrupt stack fault missed");

    chk_fault_quiet: assert property (@(posedge ref_clk) disable iff (cold_rst)
        !stack_fault |=> !hang_fault_reset)
        else $error("fault reset without enabled fault");

    // Hang resets leave the retained state alone
    chk_hang_keeps: assert property (@(posedge ref_clk) disable iff (cold_rst)
        hang_fault_reset && !flag_read && !sel_take |=> $stable(carry_disable) && $stable(stack_sel))
        else $error("hang reset changed retained state");

    chk_fault_sticky: assert property (@(posedge ref_clk) disable iff (cold_rst)
        fault_reset_flag |=> fault_reset_flag)
        else $error("fault flag lost without cold reset");

    // Chip-enable reset only on a pulse rise
    chk_ce_timing: assert property (@(posedge ref_clk) disable iff (cold_rst)
        ce_reset |-> $past(chip_enable) && $past(carry_pulse) && !$past(pulse_q))
        else $error("ce reset outside pulse rise");

    chk_ce_fires: assert property (@(posedge ref_clk) disable iff (cold_rst)
        chip_enable && pulse_rise |=> ce_reset)
        else $error("ce reset missed a pulse rise");

    // Main scenarios
    cov_cold_then_read: cover property (@(posedge ref_clk) carry_disable ##1 flag_read ##[1:50] timer_carry_flag);

    cov_sel_write: cover property (@(posedge ref_clk) sel_take ##[1:20] hang_fault_reset);

    cov_ce_reset: cover property (@(posedge ref_clk) ce_reset);

    cov_read_meets_rise: cover property (@(posedge ref_clk) flag_read && pulse_rise && !carry_disable);

    cov_sel_refused: cover property (@(posedge ref_clk) sel_locked && sel_wr.wr);
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pfd_pkg::*;
    logic           ref_clk = 0, sys_rst = 1, por_clear = 0, reset_pin_n = 1;
    logic           chip_enable = 0, carry_pulse = 0, flag_read = 0;
    pfd_sel_wr_t    sel_wr = '0;
    pfd_stack_evt_t stack_evt = '0;
    logic           flag, dis, locked, hang, ce_rst, fflag, h1, h2;
    logic [1:0]     sel;
    int             bad_count = 0, tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    pfd_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_clear(por_clear), .reset_pin_n(reset_pin_n),
        .chip_enable(chip_enable), .carry_pulse(carry_pulse), .flag_read(flag_read), .sel_wr(sel_wr),
        .stack_evt(stack_evt), .timer_carry_flag(flag), .carry_disable(dis), .stack_sel(sel),
        .sel_locked(locked), .hang_fault_reset(hang), .ce_reset(ce_rst), .fault_reset_flag(fflag));
    ////////////////////////////////////////////////////////////////////////////////
    task step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task chk(input logic [3:0] a, input logic [3:0] e, input string m);
        tests_run++;
        if (a !== e) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task pulse_rise;
        carry_pulse = 1;
        step(1);
        carry_pulse = 0;
        step(1);
    endtask
    task read_flag;
        flag_read = 1;
        step(1);
        flag_read = 0;
        step(1);
    endtask
    // Pulse outputs may land one or two edges late, so look at both
    task fault(input logic [3:0] e, input logic exp);
        stack_evt = e;
        step(1);
        h1 = hang;
        stack_evt = '0;
        step(1);
        h2 = hang;
        chk(h1 | h2, exp, "stack fault reset pulse wrong");
        step(2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        step(6);
        sys_rst = 0;
        step(1);
        chk(dis, 1, "disable not set at reset");
        chk(flag, 0, "flag not clear at reset");
        chk({locked, 1'b0}, 2'h0, "lock set at reset");
        chk(sel, SEL_RST_VAL, "selection default wrong");
        pulse_rise;
        chk(flag, 0, "flag set while disabled");
        read_flag;
        chk(dis, 0, "read did not clear disable");
        pulse_rise;
        chk(flag, 1, "flag not set by pulse");
        read_flag;
        chk(flag, 0, "read did not clear flag");
        $display("test carry done");
        sel_wr = '{1'b1, 2'h1};
        step(1);
        sel_wr = '{1'b1, 2'h2};
        step(1);
        sel_wr = '0;
        step(1);
        chk(sel, 2'h1, "second selection write taken");
        chk(locked, 1, "lock not set");
        fault(4'b1000, 1);
        fault(4'b0100, 1);
        fault(4'b0010, 0);
        fault(4'b0001, 0);
        chk(fflag, 1, "fault flag not set");
        chk({sel, dis}, 3'b010, "state lost on hang reset");
        $display("test stack done");
        chip_enable = 1;
        carry_pulse = 1;
        step(1);
        h1 = ce_rst;
        carry_pulse = 0;
        step(1);
        h2 = ce_rst;
        chip_enable = 0;
        chk(h1 | h2, 1, "no chip enable reset");
        chk(flag, 1, "flag not 1 at chip enable reset");
        flag_read = 1;
        carry_pulse = 1;
        step(1);
        flag_read = 0;
        carry_pulse = 0;
        step(1);
        chk(flag, 1, "carry event lost to read");
        $display("test ce done");
        reset_pin_n = 0;
        step(1);
        reset_pin_n = 1;
        step(1);
        chk({dis, flag}, 2'b10, "pin reset carry state wrong");
        chk({locked, fflag}, 2'b00, "pin reset lock or fault flag wrong");
        sel_wr = '{1'b1, 2'h2};
        step(1);
        sel_wr = '0;
        step(1);
        chk(sel, 2'h2, "write after pin reset refused");
        por_clear = 1;
        step(1);
        por_clear = 0;
        step(1);
        chk({dis, flag}, 2'b10, "power-on clear carry state wrong");
        chk(sel, SEL_RST_VAL, "power-on clear kept selection");
        $display("test cold done");
        finish_test;
    end
    initial begin
        #20000;
        bad_count++;
        finish_test;
    end
endmodule
